// file: hw/dpfdd_pkg.sv
`default_nettype none
package dpfdd_pkg;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_HOLDOVER = 2'b01,
    MODE_FREERUN = 2'b10
  } dpfdd_mode_type;

  typedef enum logic [1:0] {
    ROLE_PRIMARY = 2'b00,
    ROLE_SECONDARY = 2'b01,
    ROLE_SLAVE = 2'b10
  } dpfdd_role_type;

  typedef enum logic [1:0] {
    REF_8K = 2'b00,
    REF_E1 = 2'b01,
    REF_T1 = 2'b10,
    REF_BUS8M = 2'b11
  } dpfdd_ref_type;

  typedef struct packed {
    logic fastClk;
    logic busClk;
    logic e1Clk;
    logic t1Clk;
    logic busFramePulse_n;
  } dpfdd_clk_type;

  localparam int CORE_CLK_HZ = 10_000_000;
  localparam int STORE_PERIOD_MS = 32;
  localparam int STORE_PERIOD_CYC = STORE_PERIOD_MS * (CORE_CLK_HZ / 1000);
  localparam int SLOPE_STEP_PS = 7600;
  localparam int PHASE_LSB_PS = 1900;
  localparam int SLOPE_LIMIT_LSB = SLOPE_STEP_PS / PHASE_LSB_PS;
  localparam int ERR_W = 16;
  localparam int OFS_W = 32;
  localparam int FRAME_TICKS = 8192;
  localparam int FRAME_W = 13;
  localparam int FRAME_LOW_TICKS = 4;
  localparam int BUS_CLK_BIT = 2;
  localparam int E1_CLK_BIT = 4;
  localparam int T1_ACC_W = 13;
  localparam int T1_INC = 386;
  localparam logic [OFS_W-1:0] CENTRE_INC = 32'hD1B71759;
  localparam int NARROW_KI_SHIFT = 2;
  localparam int NARROW_KP_SHIFT = 8;
  localparam int WIDE_KP_SHIFT = 16;
  localparam logic [OFS_W-1:0] OFS_RESET = 32'h00000000;
endpackage
`default_nettype wire

// file: hw/dpfdd_nco.sv
`timescale 1ns/10ps
`default_nettype none
module dpfdd_nco #(
  parameter int ACC_W = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Step control
  input wire logic en,
  input wire logic [ACC_W-1:0] inc,
  // Overflow tick
  output var logic carry
);
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W:0] sum;

  assign sum = {1'b0, acc_reg} + {1'b0, inc};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_reg <= '0;
      carry <= 1'b0;
    end else begin
      carry <= en & sum[ACC_W];
      if (en) begin
        acc_reg <= sum[ACC_W-1:0];
      end
    end
  end
endmodule // dpfdd_nco
`default_nettype wire

// file: hw/dpfdd_filter_dco_divider.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Limit phase step to 7.6 ns per 125 us
// - First-order filter gives oscillator frequency offset
// - Primary master, narrow reference: narrow 1.52 Hz setting
// - Bus-rate reference selects wide 100 kHz setting
// - Filter holds stored value for holdover
// - Oscillator step is centre plus offset
// - Normal mode locks oscillator to reference
// - Holdover keeps earlier normal-mode frequency
// - Freerun uses centre frequency, zero offset
// - Divider makes the internal fast clock
// - Divider makes bus, E1, T1 clocks, frame
// - Divided clocks have 50 percent duty
// - Bus clock rise while frame low marks boundary
// - 8 kHz reference rising edge places frame
// - E1/T1 reference: frame free, bus relation kept
// - Bus-rate reference: frame follows backplane frame
// - Feedback mux picks matching divider output
// - Slave and secondary: no step limit, track edges; wide setting only on bus-rate reference
// - Primary master loop is type 2 on narrow references; bus-rate path is proportional only
// - Discrete steps keep freerun error tiny
// - Holdover output stays on stored frequency
// - Freerun request in holdover enters freerun
// - Save every 32 ms alternately; restore older
module dpfdd_filter_dco_divider #(
  parameter int STORE_PERIOD_CYC = dpfdd_pkg::STORE_PERIOD_CYC,
  parameter logic [31:0] CENTRE_INC = dpfdd_pkg::CENTRE_INC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Mode control
  input wire dpfdd_pkg::dpfdd_mode_type modeSel,
  input wire dpfdd_pkg::dpfdd_role_type roleSel,
  input wire dpfdd_pkg::dpfdd_ref_type refSel,
  input wire logic freerunRequestBit,
  input wire logic lockedIn,
  // Phase error from detector
  input wire logic signed [15:0] phaseErr,
  input wire logic phaseErrValid,
  // Reference pins
  input wire logic ref8kIn,
  input wire logic bpFramePulseIn_n,
  // Clocks and status
  output var dpfdd_pkg::dpfdd_clk_type clkOut,
  output var logic feedbackOut,
  output var logic signed [31:0] freqOffsetOut,
  output var dpfdd_pkg::dpfdd_mode_type effModeOut
);
  localparam int LIM = dpfdd_pkg::SLOPE_LIMIT_LSB;
  localparam int CNT_W = $clog2(STORE_PERIOD_CYC + 1);

  dpfdd_pkg::dpfdd_mode_type effMode_reg;
  dpfdd_pkg::dpfdd_mode_type effMode_next;
  dpfdd_pkg::dpfdd_clk_type clkOut_reg;
  logic freerunLatch_reg;
  logic [1:0] pinS1_reg;
  logic [1:0] pinS2_reg;
  logic [1:0] pinS3_reg;
  logic [1:0] pinStable_reg;
  logic [1:0] pinPrev_reg;
  logic ref8kRise;
  logic bpFrameFall;
  logic limitOn;
  logic signed [15:0] limErr;
  logic signed [15:0] limErr_reg;
  logic errStb_reg;
  logic signed [31:0] errExt;
  logic signed [31:0] integ_reg;
  logic signed [31:0] filterOfs_reg;
  logic signed [31:0] freqOffset_reg;
  logic signed [31:0] store_reg [2];
  logic storePtr_reg;
  logic signed [31:0] holdValue_reg;
  logic [CNT_W-1:0] saveCnt_reg;
  logic saveTick;
  logic [31:0] dcoInc;
  logic fastTick;
  logic t1Tog;
  logic [12:0] frameCnt_reg;
  logic alignEvt;
  logic feedback_reg;

  assign clkOut = clkOut_reg;
  assign feedbackOut = feedback_reg;
  assign freqOffsetOut = freqOffset_reg;
  assign effModeOut = effMode_reg;

  // Modes are chosen by an outside state machine
  always_comb begin
    effMode_next = modeSel;
    if (modeSel == dpfdd_pkg::MODE_HOLDOVER && (freerunRequestBit || freerunLatch_reg)) begin
      effMode_next = dpfdd_pkg::MODE_FREERUN;
    end
  end

  // A pulse on the request is enough; held until holdover is left
  always_ff @(posedge core_clk) begin
    if (rst) begin
      freerunLatch_reg <= 1'b0;
      effMode_reg <= dpfdd_pkg::MODE_NORMAL;
    end else begin
      effMode_reg <= effMode_next;
      if (modeSel != dpfdd_pkg::MODE_HOLDOVER) begin
        freerunLatch_reg <= 1'b0;
      end else if (freerunRequestBit) begin
        freerunLatch_reg <= 1'b1;
      end
    end
  end

  // Pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinS1_reg <= 2'h3;
      pinS2_reg <= 2'h3;
      pinS3_reg <= 2'h3;
      pinStable_reg <= 2'h3;
      pinPrev_reg <= 2'h3;
    end else begin
      pinS1_reg <= {bpFramePulseIn_n, ref8kIn};
      pinS2_reg <= pinS1_reg;
      pinS3_reg <= pinS2_reg;
      pinPrev_reg <= pinStable_reg;
      for (int i = 0; i < 2; i++) begin
        if (pinS2_reg[i] == pinS3_reg[i]) begin
          pinStable_reg[i] <= pinS3_reg[i];
        end
      end
    end
  end

  assign ref8kRise = pinStable_reg[0] & ~pinPrev_reg[0];
  assign bpFrameFall = ~pinStable_reg[1] & pinPrev_reg[1];

  // Limiter only acts when the loop attenuates; bus-rate tracking must pass edges
  assign limitOn = roleSel == dpfdd_pkg::ROLE_PRIMARY && refSel != dpfdd_pkg::REF_BUS8M;

  always_comb begin
    limErr = phaseErr;
    if (limitOn && phaseErr > 16'(LIM)) begin
      limErr = 16'(LIM);
    end else if (limitOn && phaseErr < -16'(LIM)) begin
      limErr = -16'(LIM);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      limErr_reg <= '0;
      errStb_reg <= 1'b0;
    end else begin
      errStb_reg <= phaseErrValid;
      if (phaseErrValid) begin
        limErr_reg <= limErr;
      end
    end
  end

  assign errExt = 32'(limErr_reg);

  // Proportional plus integral path forms the type 2 loop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      integ_reg <= dpfdd_pkg::OFS_RESET;
      filterOfs_reg <= dpfdd_pkg::OFS_RESET;
    end else if (effMode_reg != dpfdd_pkg::MODE_NORMAL) begin
      // Preload so a return to normal starts from the held frequency
      integ_reg <= holdValue_reg;
      filterOfs_reg <= holdValue_reg;
    end else if (errStb_reg) begin
      if (refSel == dpfdd_pkg::REF_BUS8M) begin
        filterOfs_reg <= integ_reg + (errExt <<< dpfdd_pkg::WIDE_KP_SHIFT);
      end else begin
        integ_reg <= integ_reg + (errExt <<< dpfdd_pkg::NARROW_KI_SHIFT);
        filterOfs_reg <= integ_reg + (errExt <<< dpfdd_pkg::NARROW_KP_SHIFT);
      end
    end
  end

  // Save period counter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      saveCnt_reg <= '0;
    end else if (saveTick) begin
      saveCnt_reg <= '0;
    end else begin
      saveCnt_reg <= saveCnt_reg + 1'b1;
    end
  end

  assign saveTick = saveCnt_reg == CNT_W'(STORE_PERIOD_CYC - 1);

  // Two alternating stores; the older is never younger than one period
  always_ff @(posedge core_clk) begin
    if (rst) begin
      store_reg[0] <= dpfdd_pkg::OFS_RESET;
      store_reg[1] <= dpfdd_pkg::OFS_RESET;
      storePtr_reg <= 1'b0;
    end else if (saveTick && lockedIn && effMode_reg == dpfdd_pkg::MODE_NORMAL) begin
      store_reg[storePtr_reg] <= filterOfs_reg;
      storePtr_reg <= ~storePtr_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      holdValue_reg <= dpfdd_pkg::OFS_RESET;
    end else if (effMode_next == dpfdd_pkg::MODE_HOLDOVER && effMode_reg == dpfdd_pkg::MODE_NORMAL) begin
      holdValue_reg <= store_reg[storePtr_reg];
    end
  end

  // Offset chosen per mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      freqOffset_reg <= dpfdd_pkg::OFS_RESET;
    end else begin
      case (effMode_reg)
        dpfdd_pkg::MODE_NORMAL: begin
          freqOffset_reg <= filterOfs_reg;
        end
        dpfdd_pkg::MODE_HOLDOVER: begin
          freqOffset_reg <= holdValue_reg;
        end
        default: begin
          freqOffset_reg <= dpfdd_pkg::OFS_RESET;
        end
      endcase
    end
  end

  // 32-bit step keeps frequency quantisation far below 0.03 ppm
  assign dcoInc = CENTRE_INC + freqOffset_reg;

  // Fast tick runs scaled below the core clock; it stands in for the fast clock
  dpfdd_nco #(.ACC_W(32)) uDco (
    .core_clk(core_clk),
    .rst(rst),
    .en(1'b1),
    .inc(dcoInc),
    .carry(fastTick)
  );

  dpfdd_nco #(.ACC_W(dpfdd_pkg::T1_ACC_W)) uT1 (
    .core_clk(core_clk),
    .rst(rst),
    .en(fastTick),
    .inc(13'(dpfdd_pkg::T1_INC)),
    .carry(t1Tog)
  );

  // E1/T1 references never realign, so their frame phase is arbitrary
  assign alignEvt = effMode_reg == dpfdd_pkg::MODE_NORMAL &&
    ((refSel == dpfdd_pkg::REF_8K && ref8kRise) ||
     (refSel == dpfdd_pkg::REF_BUS8M && bpFrameFall));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      frameCnt_reg <= '0;
    end else if (alignEvt) begin
      frameCnt_reg <= '0;
    end else if (fastTick) begin
      frameCnt_reg <= frameCnt_reg + 1'b1;
    end
  end

  // Bus, E1 and frame outputs decode one counter, so frame and bus clock cannot drift apart
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clkOut_reg <= 5'h01;
    end else begin
      clkOut_reg.fastClk <= fastTick;
      clkOut_reg.busClk <= ~frameCnt_reg[dpfdd_pkg::BUS_CLK_BIT];
      clkOut_reg.e1Clk <= ~frameCnt_reg[dpfdd_pkg::E1_CLK_BIT];
      clkOut_reg.t1Clk <= clkOut_reg.t1Clk ^ t1Tog;
      clkOut_reg.busFramePulse_n <= ~(frameCnt_reg >= 13'(dpfdd_pkg::FRAME_TICKS - dpfdd_pkg::FRAME_LOW_TICKS) ||
        frameCnt_reg < 13'(dpfdd_pkg::FRAME_LOW_TICKS));
    end
  end

  // Feedback mux
  always_ff @(posedge core_clk) begin
    if (rst) begin
      feedback_reg <= 1'b0;
    end else begin
      case (refSel)
        dpfdd_pkg::REF_8K: feedback_reg <= clkOut_reg.busFramePulse_n;
        dpfdd_pkg::REF_E1: feedback_reg <= clkOut_reg.e1Clk;
        dpfdd_pkg::REF_T1: feedback_reg <= clkOut_reg.t1Clk;
        default: feedback_reg <= clkOut_reg.busClk;
      endcase
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_slope;
    phaseErrValid && limitOn |=> limErr_reg <= 16'(LIM) && limErr_reg >= -16'(LIM);
  endproperty
  a_slope: assert property (p_slope) else $error("phase step over limit");

  property p_freerun;
    effMode_reg == dpfdd_pkg::MODE_FREERUN |=> freqOffset_reg == 0;
  endproperty
  a_freerun: assert property (p_freerun) else $error("freerun offset not zero");

  property p_hold;
    effMode_reg == dpfdd_pkg::MODE_HOLDOVER [*3] |-> $stable(freqOffset_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("holdover offset moved");

  property p_freerunReq;
    modeSel == dpfdd_pkg::MODE_HOLDOVER && freerunRequestBit
      ##1 modeSel == dpfdd_pkg::MODE_HOLDOVER |-> effMode_reg == dpfdd_pkg::MODE_FREERUN;
  endproperty
  a_freerunReq: assert property (p_freerunReq) else $error("freerun request ignored");

  property p_holdEntry;
    effMode_next == dpfdd_pkg::MODE_HOLDOVER && effMode_reg == dpfdd_pkg::MODE_NORMAL
      |=> holdValue_reg == $past(store_reg[storePtr_reg]) ##1 freqOffset_reg == $past(holdValue_reg);
  endproperty
  a_holdEntry: assert property (p_holdEntry) else $error("holdover not from older store");

  property p_boundary;
    $rose(clkOut_reg.busClk) && !clkOut_reg.busFramePulse_n |-> $past(frameCnt_reg) == 0;
  endproperty
  a_boundary: assert property (p_boundary) else $error("frame boundary off bus clock");

  property p_align;
    alignEvt |=> frameCnt_reg == 0 ##1 !clkOut_reg.busFramePulse_n;
  endproperty
  a_align: assert property (p_align) else $error("frame not aligned to reference");

  property p_bpAlign;
    effMode_reg == dpfdd_pkg::MODE_NORMAL && refSel == dpfdd_pkg::REF_BUS8M && bpFrameFall |=> frameCnt_reg == 0;
  endproperty
  a_bpAlign: assert property (p_bpAlign) else $error("backplane frame not followed");

  property p_feedback;
    refSel == dpfdd_pkg::REF_E1 |=> feedback_reg == $past(clkOut_reg.e1Clk);
  endproperty
  a_feedback: assert property (p_feedback) else $error("wrong feedback selected");

  c_holdEntry: cover property (effMode_reg == dpfdd_pkg::MODE_NORMAL ##1 effMode_reg == dpfdd_pkg::MODE_HOLDOVER);
  c_freerun: cover property (effMode_reg == dpfdd_pkg::MODE_HOLDOVER ##1 effMode_reg == dpfdd_pkg::MODE_FREERUN);
  c_align: cover property (alignEvt);
  c_clamp: cover property (phaseErrValid && limitOn && limErr != phaseErr);
endmodule // dpfdd_filter_dco_divider
`default_nettype wire

// file: dv/dpfdd_ref_source.sv
`timescale 1ns/10ps
`default_nettype none
module dpfdd_ref_source (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Edge request
  input wire logic fire,
  // Reference pins
  output var logic ref8kIn,
  output var logic bpFramePulseIn_n
);
  logic [2:0] holdCnt_reg;
  // Pins rest at pulled levels between frames, so no stale edge leaks out
  always_ff @(posedge core_clk) begin
    if (rst) begin
      holdCnt_reg <= 3'h0;
    end else if (fire) begin
      holdCnt_reg <= 3'h7;
    end else if (holdCnt_reg != 3'h0) begin
      holdCnt_reg <= holdCnt_reg - 3'h1;
    end
  end
  assign ref8kIn = (holdCnt_reg != 3'h0);
  assign bpFramePulseIn_n = (holdCnt_reg == 3'h0);
endmodule // dpfdd_ref_source
`default_nettype wire

// file: dv/dpfdd_filter_dco_divider_test.sv
`timescale 1ns/10ps
`default_nettype none
module dpfdd_filter_dco_divider_test;
  typedef struct {int cyc; int kind; logic [31:0] val;} dpfdd_exp_type;
  localparam int FB_BIT [4] = '{0, 2, 1, 3};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  dpfdd_pkg::dpfdd_mode_type modeSel = dpfdd_pkg::MODE_NORMAL;
  dpfdd_pkg::dpfdd_role_type roleSel = dpfdd_pkg::ROLE_SLAVE;
  dpfdd_pkg::dpfdd_ref_type refSel = dpfdd_pkg::REF_BUS8M;
  logic freerunRequestBit = 1'b0;
  logic lockedIn = 1'b1;
  logic signed [15:0] phaseErr = 16'sh0000;
  logic phaseErrValid = 1'b0;
  logic fire = 1'b0;
  logic ref8kIn;
  logic bpFramePulseIn_n;
  logic feedbackOut;
  dpfdd_pkg::dpfdd_clk_type clkOut;
  logic signed [31:0] freqOffsetOut;
  dpfdd_pkg::dpfdd_mode_type effModeOut;
  int cyc = 0;
  int n_mismatch = 0;
  int checks_done = 0;
  int integ = 0;
  int lastOfs = 0;
  int holdA;
  int per;
  int on;
  int rb;
  logic pv;
  dpfdd_exp_type q[$];

  dpfdd_filter_dco_divider #(.STORE_PERIOD_CYC(64)) dut (
    .core_clk(core_clk), .rst(rst), .modeSel(modeSel), .roleSel(roleSel), .refSel(refSel),
    .freerunRequestBit(freerunRequestBit), .lockedIn(lockedIn), .phaseErr(phaseErr),
    .phaseErrValid(phaseErrValid), .ref8kIn(ref8kIn), .bpFramePulseIn_n(bpFramePulseIn_n),
    .clkOut(clkOut), .feedbackOut(feedbackOut), .freqOffsetOut(freqOffsetOut), .effModeOut(effModeOut));
  dpfdd_ref_source src (.core_clk(core_clk), .rst(rst), .fire(fire), .ref8kIn(ref8kIn),
    .bpFramePulseIn_n(bpFramePulseIn_n));

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] obs(input int k);
    case (k)
      0: obs = freqOffsetOut;
      1: obs = {30'h0, effModeOut};
      default: obs = {27'h0, clkOut};
    endcase
  endfunction

  // Results are judged at the falling edge, once the rising edge has settled
  always @(negedge core_clk) begin
    while (q.size() > 0 && q[0].cyc <= cyc) begin
      cmp(obs(q[0].kind), q[0].val);
      void'(q.pop_front());
    end
  end

  task automatic expect_at(input int d, input int k, input logic [31:0] v);
    q.push_back('{cyc + d, k, v});
  endtask

  task automatic send_err(input int e, input bit clampOn, input bit wide);
    int lim;
    @(posedge core_clk);
    lim = clampOn ? ((e > 4) ? 4 : ((e < -4) ? -4 : e)) : e;
    phaseErr <= 16'(e);
    phaseErrValid <= 1'b1;
    lastOfs = wide ? lim * 65536 : integ + lim * 256;
    expect_at(4, 0, 32'(lastOfs));
    if (!wide) begin
      integ += lim * 4;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge core_clk);
      phaseErrValid <= 1'b0;
    end
  endtask

  task automatic meas(input int b, input logic act, output int p, output int o, output int r);
    logic prv;
    logic pb;
    int n;
    p = 0;
    o = 0;
    r = 0;
    n = 0;
    prv = act;
    pb = 1'b1;
    while (!(prv !== act && clkOut[b] === act) && n < 30000) begin
      prv = clkOut[b];
      pb = clkOut.busClk;
      @(negedge core_clk);
      n++;
    end
    do begin
      if (clkOut.fastClk === 1'b1) begin
        p++;
        if (clkOut[b] === act) o++;
      end
      if (clkOut[b] === act && pb === 1'b0 && clkOut.busClk === 1'b1) r++;
      pb = clkOut.busClk;
      prv = clkOut[b];
      @(negedge core_clk);
      n++;
    end while (!(prv !== act && clkOut[b] === act) && n < 60000);
  endtask

  task automatic align(input int r, input logic exp);
    logic seen;
    @(posedge core_clk);
    refSel <= dpfdd_pkg::dpfdd_ref_type'(r);
    repeat (200) @(posedge core_clk);
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    seen = 1'b0;
    repeat (14) begin
      @(negedge core_clk);
      if (clkOut.busFramePulse_n === 1'b0) seen = 1'b1;
    end
    cmp({31'h0, seen}, {31'h0, exp});
  endtask

  initial begin
    #8_000_000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h697D));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    cmp({27'h0, clkOut}, 32'h00000001);
    cmp({29'h0, feedbackOut, effModeOut}, 32'h00000000);
    // Slave on bus clock: wide path, no clamp; request ignored outside holdover
    @(posedge core_clk);
    freerunRequestBit <= 1'b1;
    expect_at(3, 1, dpfdd_pkg::MODE_NORMAL);
    send_err(100, 0, 1);
    roleSel <= dpfdd_pkg::ROLE_SECONDARY;
    send_err(int'($urandom_range(400, 0)) - 200, 0, 1);
    idle(6);
    freerunRequestBit <= 1'b0;
    roleSel <= dpfdd_pkg::ROLE_PRIMARY;
    lastOfs = 0;
    for (int r = 0; r < 3; r++) begin
      refSel <= dpfdd_pkg::dpfdd_ref_type'(r);
      idle(2);
      send_err(300, 1, 0);
      send_err(-300, 1, 0);
      for (int i = 0; i < 4; i++) send_err(int'($urandom_range(400, 0)) - 200, 1, 0);
      send_err(3, 1, 0);
      idle(6);
    end
    // Both stores settle on A, then a late change must not reach holdover
    idle(140);
    holdA = lastOfs;
    lockedIn <= 1'b0;
    send_err(2, 1, 0);
    idle(140);
    // Unlocked saves are skipped; one locked save then fills only the newer store
    lockedIn <= 1'b1;
    idle(64);
    modeSel <= dpfdd_pkg::MODE_HOLDOVER;
    expect_at(3, 1, dpfdd_pkg::MODE_HOLDOVER);
    expect_at(4, 0, 32'(holdA));
    idle(4);
    phaseErr <= 16'sd50;
    phaseErrValid <= 1'b1;
    expect_at(8, 0, 32'(holdA));
    idle(10);
    freerunRequestBit <= 1'b1;
    expect_at(3, 1, dpfdd_pkg::MODE_FREERUN);
    expect_at(4, 0, 32'h00000000);
    idle(1);
    freerunRequestBit <= 1'b0;
    expect_at(20, 1, dpfdd_pkg::MODE_FREERUN);
    idle(25);
    meas(3, 1'b1, per, on, rb);
    cmp(per, 8);
    cmp(on, 4);
    meas(2, 1'b1, per, on, rb);
    cmp(per, 32);
    cmp(on, 16);
    meas(1, 1'b1, per, on, rb);
    cmp({31'h0, per >= 42 && per <= 44}, 32'h1);
    cmp({31'h0, on >= 21 && on <= 22}, 32'h1);
    meas(0, 1'b0, per, on, rb);
    cmp(per, 8192);
    cmp(on, 8);
    cmp(rb, 1);
    for (int r = 0; r < 4; r++) begin
      @(posedge core_clk);
      refSel <= dpfdd_pkg::dpfdd_ref_type'(r);
      repeat (4) @(negedge core_clk);
      repeat (30) begin
        pv = clkOut[FB_BIT[r]];
        @(negedge core_clk);
        cmp({31'h0, feedbackOut}, {31'h0, pv});
      end
    end
    @(posedge core_clk);
    modeSel <= dpfdd_pkg::MODE_NORMAL;
    roleSel <= dpfdd_pkg::ROLE_PRIMARY;
    align(0, 1'b1);
    align(1, 1'b0);
    @(posedge core_clk);
    roleSel <= dpfdd_pkg::ROLE_SLAVE;
    align(3, 1'b1);
    idle(10);
    end_sim();
  end
endmodule // dpfdd_filter_dco_divider_test
`default_nettype wire
